// ### pkg/ftd_defs.vh
// Constants for the flash trigger divider: register map, fields, resets and timing
`ifndef FTD_DEFS_VH
`define FTD_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FTD_REG_CTRL 4'h0
`define FTD_REG_STATUS 4'h4
`define FTD_REG_COUNT 4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FTD_CTRL_EN_BIT 0
`define FTD_CTRL_SINGLE_BIT 1
`define FTD_CTRL_POS_LSB 4
`define FTD_CTRL_POS_MSB 6

// ----------------------------------------------------------------------------
// Divide ratio jumper positions and reset values
// ----------------------------------------------------------------------------
`define FTD_POS_OFF 3'h1
`define FTD_POS_DIV10 3'h2
`define FTD_POS_DIV12 3'h3
`define FTD_POS_DIV14 3'h4
`define FTD_POS_DIV16 3'h5
`define FTD_CTRL_RESET 32'h0000_0050
`define FTD_CTRL_RESET_EN 1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FTD_PULSE_NS 5000
`define FTD_CLK_NS 50
`define FTD_PULSE_CYC ((`FTD_PULSE_NS + `FTD_CLK_NS - 1) / `FTD_CLK_NS)

// AXI responses
`define FTD_RESP_OKAY 2'h0
`define FTD_RESP_SLVERR 2'h2

`endif

// ### rtl/ftd_pulse_gen.v
// Fixed width trigger pulse stretcher for the lamp output
`timescale 1ns/1ps
module ftd_pulse_gen #(
  parameter WIDTH = 100
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_srst,
  // Control
  input wire i_fire,
  input wire i_allow,
  // Output
  output wire o_pulse
);
  reg [15:0] cnt_q;
  reg pulse_q;

  // A new fire during a running pulse is merged; the lamp sees one flash
  always @(posedge i_sys_clk)
  begin
    if (i_srst || !i_allow)
    begin
      cnt_q <= 16'h0000;
      pulse_q <= 1'b0;
    end
    else if (i_fire && !pulse_q)
    begin
      cnt_q <= WIDTH[15:0] - 16'h0001;
      pulse_q <= 1'b1;
    end
    else if (pulse_q)
    begin
      if (cnt_q == 16'h0000)
        pulse_q <= 1'b0;
      else
        cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign o_pulse = pulse_q;
endmodule

// ### rtl/ftd_top.v
// Flash trigger divider with AXI4-Lite control for a pulsed xenon lamp
//
// Contract
// - Each flash is requested by one positive logic-level pulse and the lamp fires once per pulse.
// - Single flash mode gives exactly one strobe per integration cycle.
// - Multiple mode strobes at master clock over 2^10/2^12/2^14/2^16 for positions 2..5; 1 is off.
// - The divide ratio defaults to 2^16.
// - Strobes reach the lamp only while strobe enable is set by software.
// - Output rate follows the sample clock in multiple mode and the scan rate in single mode.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ftd_defs.vh"
module ftd_top #(
  parameter PULSE_CYC = `FTD_PULSE_CYC
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_srst,
  // Converter timing (external pins)
  input wire i_master_clk,
  input wire i_integ_start,
  // Lamp trigger
  output wire o_lamp_trigger,
  // AXI4-Lite write address
  input wire [3:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] o_s_axi_bresp,
  output wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0] o_s_axi_rresp,
  output wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);

  // --------------------------------------------------------------------------
  // Divide exponent lookup, shared by the divider and the status view
  // --------------------------------------------------------------------------
  // Unused codes map to zero, which the rest of the block reads as disabled except in single mode
  function [4:0] ftd_exp;
    input [2:0] pos;
    begin
      case (pos)
        `FTD_POS_DIV10: ftd_exp = 5'h0a;
        `FTD_POS_DIV12: ftd_exp = 5'h0c;
        `FTD_POS_DIV14: ftd_exp = 5'h0e;
        `FTD_POS_DIV16: ftd_exp = 5'h10;
        default: ftd_exp = 5'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // --------------------------------------------------------------------------
  reg [1:0] mclk_sync_q;
  reg [1:0] integ_sync_q;
  reg mclk_prev_q;
  reg integ_prev_q;
  wire mclk_rise;
  wire integ_rise;

  // Reset values equal the idle pin levels, so no false edge follows reset
  // Two stages before any logic; edge detect looks only at the second
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      mclk_sync_q <= 2'b00;
      integ_sync_q <= 2'b00;
      mclk_prev_q <= 1'b0;
      integ_prev_q <= 1'b0;
    end
    else
    begin
      mclk_sync_q <= {mclk_sync_q[0], i_master_clk};
      integ_sync_q <= {integ_sync_q[0], i_integ_start};
      mclk_prev_q <= mclk_sync_q[1];
      integ_prev_q <= integ_sync_q[1];
    end
  end

  assign mclk_rise = mclk_sync_q[1] & ~mclk_prev_q;
  assign integ_rise = integ_sync_q[1] & ~integ_prev_q;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Software image of the strobe enable, the mode toggle and the divider setting
  reg strobe_en_q;
  reg single_mode_q;
  reg [2:0] divide_ratio_jumper_q;
  reg [15:0] flash_count_q;
  wire pos_enabled;
  wire allow;

  // Disabled positions hold the trigger low; single mode needs no divider
  assign pos_enabled = (ftd_exp(divide_ratio_jumper_q) != 5'h00);
  assign allow = strobe_en_q & (single_mode_q | pos_enabled);

  // --------------------------------------------------------------------------
  // Divider and strobe source
  // --------------------------------------------------------------------------
  // Counter is as wide as the largest ratio, so 2^16 needs no extra bit
  reg [15:0] div_cnt_q;
  reg fire_q;
  wire [16:0] div_top;

  // Terminal count is 2^n minus one master clock edges
  assign div_top = (17'h0_0001 << ftd_exp(divide_ratio_jumper_q)) - 17'h0_0001;

  // Single mode fires at each integration start; multiple mode counts master edges
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      div_cnt_q <= 16'h0000;
      fire_q <= 1'b0;
    end
    else
    begin
      fire_q <= 1'b0;
      if (!allow || integ_rise)
      begin
        div_cnt_q <= 16'h0000;
        if (allow && single_mode_q)
          fire_q <= 1'b1;
      end
      else if (!single_mode_q && mclk_rise)
      begin
        if (div_cnt_q == div_top[15:0])
        begin
          div_cnt_q <= 16'h0000;
          fire_q <= 1'b1;
        end
        else
          div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end

  // Flash counter for software, wraps silently
  // Limitation: software must sample it before 2^16 flashes have passed
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      flash_count_q <= 16'h0000;
    else if (fire_q && allow)
      flash_count_q <= flash_count_q + 16'h0001;
  end

  // --------------------------------------------------------------------------
  // Trigger pulse output
  // --------------------------------------------------------------------------
  ftd_pulse_gen #(
    .WIDTH(PULSE_CYC)
  ) u_pulse (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_fire(fire_q),
    .i_allow(allow),
    .o_pulse(o_lamp_trigger)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  wire do_write;

  // Ready stays low while a half is parked or the answer waits: one write at a time
  assign o_s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign o_s_axi_wready = ~w_held_q & ~bvalid_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  // Address and data are captured independently, in either order
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `FTD_RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == `FTD_REG_CTRL) ? `FTD_RESP_OKAY : `FTD_RESP_SLVERR;
      end
      else if (bvalid_q && i_s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Control register; only byte lane 0 carries fields
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      strobe_en_q <= `FTD_CTRL_RESET_EN;
      single_mode_q <= 1'b0;
      divide_ratio_jumper_q <= `FTD_POS_DIV16;
    end
    else if (do_write && awaddr_q == `FTD_REG_CTRL && wstrb_q[0])
    begin
      strobe_en_q <= wdata_q[`FTD_CTRL_EN_BIT];
      single_mode_q <= wdata_q[`FTD_CTRL_SINGLE_BIT];
      divide_ratio_jumper_q <= wdata_q[`FTD_CTRL_POS_MSB:`FTD_CTRL_POS_LSB];
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire [31:0] ctrl_view;
  wire [31:0] status_view;

  // One read in flight; a new address waits until the data is taken
  assign o_s_axi_arready = ~rvalid_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign ctrl_view = {25'h000_0000, divide_ratio_jumper_q, 2'b00, single_mode_q, strobe_en_q};
  // Status packs the live trigger, integration level, gate and exponent
  assign status_view = {19'h0_0000, ftd_exp(divide_ratio_jumper_q), 5'h00, allow,
                        integ_sync_q[1], o_lamp_trigger};

  // Read data is registered; unmapped addresses answer zero with an error
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `FTD_RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `FTD_RESP_OKAY;
      case (i_s_axi_araddr)
        `FTD_REG_CTRL: rdata_q <= ctrl_view;
        `FTD_REG_STATUS: rdata_q <= status_view;
        `FTD_REG_COUNT: rdata_q <= {16'h0000, flash_count_q};
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `FTD_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && i_s_axi_rready)
      rvalid_q <= 1'b0;
  end
endmodule

// ### sim/ftd_lamp_model.sv
// Behavioural lamp trigger input that counts flashes
`timescale 1ns/1ps
module ftd_lamp_model (
  // Trigger pin
  input wire i_trig,
  // Flash count
  output integer o_flashes
);
  // One flash per positive edge; the level after it is ignored
  initial o_flashes = 0;
  always @(posedge i_trig)
    o_flashes = o_flashes + 1;
endmodule

// ### sim/ftd_top_asserts.sv
// Checker for the trigger pin and the register bus handshake
`timescale 1ns/1ps
module ftd_top_asserts #(
  parameter PULSE_CYC = 100
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_srst,
  // Lamp and bus
  input wire o_lamp_trigger,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);
  // High time of the trigger; a merged fire must not stretch it
  reg [15:0] hi_q;
  always @(posedge i_sys_clk)
    hi_q <= (i_srst || !o_lamp_trigger) ? 16'h0000 : hi_q + 16'h0001;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_wr;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rd;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  a_trig_width: assert property (o_lamp_trigger |-> hi_q < PULSE_CYC)
    else $error("trigger too long");
  a_reset_quiet: assert property ($fell(i_srst) |->
    !o_lamp_trigger && !o_s_axi_bvalid && !o_s_axi_rvalid) else $error("busy after reset");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
  a_rvalid_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
    else $error("read answer dropped");
  a_wr_answer: assert property (s_wr |-> ##[1:2] o_s_axi_bvalid)
    else $error("no write answer");
  a_rd_answer: assert property (s_rd |=> o_s_axi_rvalid)
    else $error("no read answer");
  a_wr_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken early");
  a_rd_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken early");
endmodule
bind ftd_top ftd_top_asserts #(.PULSE_CYC(PULSE_CYC)) i_ftd_top_asserts (
  .i_sys_clk, .i_srst, .o_lamp_trigger, .i_s_axi_awvalid, .o_s_axi_awready,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready
);

// ### sim/testbench.sv
// Self-checking bench for the flash trigger divider
`timescale 1ns/1ps
`include "ftd_defs.vh"
`define CHK(nm, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) begin \
  err_count = err_count + 1; $display("FAIL %s exp %h got %h", nm, e, s); end end
module testbench;
  localparam PC = 4;
  // Stimulus and observed pins
  reg clk = 1'b0, srst = 1'b1, mclk = 1'b0, integ = 1'b0;
  reg [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  reg [31:0] wdata = 32'h0000_0000, rnd;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  wire trig, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [33:0] exp_q[$];
  reg [33:0] e;
  integer flashes, base = 0, p, i, seed = 21, err_count = 0, n_tests = 0;
  always #25 clk = ~clk;
  ftd_top #(.PULSE_CYC(PC)) i_ftd_top (
    .i_sys_clk(clk), .i_srst(srst), .i_master_clk(mclk), .i_integ_start(integ),
    .o_lamp_trigger(trig), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  ftd_lamp_model i_ftd_lamp_model (.i_trig(trig), .o_flashes(flashes));
  task give_verdict;
    begin
      if (err_count == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // A used-up wait counts as a mismatch
  task tmo(input integer k);
    if (k > 200)
    begin
      err_count = err_count + 1;
      $display("FAIL wait exp %0d got %0d", 200, k);
      give_verdict;
    end
  endtask
  // One access: offer, hold each channel until taken, then await the answer
  task axi(input wr, input [3:0] a, input [31:0] d, input [3:0] s, input [33:0] x);
    integer k;
    reg ha, hw, hr, dn;
    begin
      exp_q.push_back(x);
      ha = wr;
      hw = wr;
      hr = !wr;
      dn = 1'b0;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      wstrb <= s;
      bready <= wr;
      rready <= !wr;
      for (k = 0; ha || hw || hr; k = k + 1)
      begin
        awvalid <= ha;
        wvalid <= hw;
        arvalid <= hr;
        tmo(k);
        @(negedge clk);
        ha = ha && !awready;
        hw = hw && !wready;
        hr = hr && !arready;
        @(posedge clk);
      end
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      arvalid <= 1'b0;
      for (k = 0; !dn; k = k + 1)
      begin
        tmo(k);
        @(negedge clk);
        dn = wr ? bvalid : rvalid;
        @(posedge clk);
      end
      bready <= 1'b0;
      rready <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Master clock rises; two cycles per level so the synchroniser sees each
  task mrise(input integer n);
    repeat (n)
    begin
      repeat (2) @(posedge clk);
      mclk <= 1'b1;
      repeat (2) @(posedge clk);
      mclk <= 1'b0;
    end
  endtask
  // Integration start; the gap stands for the 5 ms minimum period, shortened in time
  task istart;
    begin
      integ <= 1'b1;
      repeat (6) @(posedge clk);
      integ <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  // Flashes since the previous check
  task fchk(input integer n);
    begin
      repeat (PC + 12) @(posedge clk);
      `CHK("flashes", n, flashes - base)
      base = flashes;
    end
  endtask
  // Oldest expectation against each bus answer
  always @(negedge clk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      e = exp_q.pop_front();
      `CHK("bus", e, bvalid ? {bresp, 32'h0000_0000} : {rresp, rdata})
    end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rnd = $random(seed);
    axi(0, `FTD_REG_CTRL, 0, 0, {`FTD_RESP_OKAY, `FTD_CTRL_RESET});
    axi(0, 4'hc, 0, 0, {`FTD_RESP_SLVERR, 32'h0000_0000});
    axi(1, 4'hc, rnd, rnd[7:4], {`FTD_RESP_SLVERR, 32'h0000_0000});
    istart;
    mrise(1100);
    fchk(0);
    axi(1, `FTD_REG_CTRL, 32'h0000_0011, 4'hf, {`FTD_RESP_OKAY, 32'h0000_0000});
    mrise(1100);
    fchk(0);
    for (p = 2; p <= 5; p = p + 1)
    begin
      axi(1, `FTD_REG_CTRL, 1 | (p << 4), 4'hf, {`FTD_RESP_OKAY, 32'h0000_0000});
      mrise(p == 2 ? 1000 : 0);
      istart;
      mrise(p < 4 ? (1 << (2 * p + 6)) - 1 : 4100);
      fchk(0);
      mrise(1);
      fchk(p < 4);
    end
    axi(1, `FTD_REG_CTRL, 32'h0000_0053, 4'hf, {`FTD_RESP_OKAY, 32'h0000_0000});
    for (i = 0; i < 3; i = i + 1)
    begin
      istart;
      mrise(50);
    end
    fchk(3);
    axi(1, `FTD_REG_CTRL, 32'h0000_0052, 4'hf, {`FTD_RESP_OKAY, 32'h0000_0000});
    axi(1, `FTD_REG_CTRL, 32'h0000_0000, 4'he, {`FTD_RESP_OKAY, 32'h0000_0000});
    axi(0, `FTD_REG_CTRL, 0, 0, {`FTD_RESP_OKAY, 32'h0000_0052});
    axi(0, `FTD_REG_COUNT, 0, 0, {`FTD_RESP_OKAY, 16'h0000, flashes[15:0]});
    axi(0, `FTD_REG_STATUS, 0, 0, {`FTD_RESP_OKAY, 32'h0000_1000});
    istart;
    fchk(0);
    give_verdict;
  end
endmodule
